// [include/tmc_defs.vh]
`ifndef TMC_DEFS_VH
`define TMC_DEFS_VH
// register word addresses
`define TMC_ADDR_CTRL 4'h0
`define TMC_ADDR_COUNT 4'h1
`define TMC_ADDR_CMPA 4'h2
`define TMC_ADDR_CMPB 4'h3
`define TMC_ADDR_FLAGS 4'h4
`define TMC_ADDR_PINS 4'h5
// control register fields
`define TMC_CTRL_WGM_LO 0
`define TMC_CTRL_WGM_HI 2
`define TMC_CTRL_COMA_LO 4
`define TMC_CTRL_COMA_HI 5
`define TMC_CTRL_COMB_LO 6
`define TMC_CTRL_COMB_HI 7
`define TMC_CTRL_FOCA 8
`define TMC_CTRL_FOCB 9
// flag register fields
`define TMC_FLAG_TOV 0
`define TMC_FLAG_CFA 1
`define TMC_FLAG_CFB 2
// pin register fields
`define TMC_PIN_DIRA 0
`define TMC_PIN_DIRB 1
`define TMC_PIN_LATA 2
`define TMC_PIN_LATB 3
`define TMC_PIN_STA 4
`define TMC_PIN_STB 5
// mode and action encodings
`define TMC_WGM_NORMAL 3'h0
`define TMC_WGM_CTC 3'h2
`define TMC_COM_NONE 2'h0
`define TMC_COM_TOGGLE 2'h1
`define TMC_COM_CLEAR 2'h2
`define TMC_COM_SET 2'h3
// values
`define TMC_CNT_MAX 8'hff
`define TMC_CNT_ZERO 8'h00
`define TMC_CNT_ONE 8'h01
`define TMC_WORD_ZERO 32'h00000000
`endif

// [rtl/tmc_timer8.v]
`timescale 1ns/1ns
`default_nettype none
`include "tmc_defs.vh"
module tmc_timer8 (
    input wire ref_clk_i, // system clock, 100 MHz
    input wire rst_i, // synchronous reset, active high
    input wire ce_i, // clock enable, freezes all state when low
    input wire tick_i, // prescaled timer clock enable
    input wire [3:0] avs_address_i, // word address
    input wire avs_read_i, // read request
    input wire avs_write_i, // write request
    input wire [31:0] avs_writedata_i, // write data
    input wire [3:0] avs_byteenable_i, // byte lanes
    input wire irq_ack_ovf_i, // overflow interrupt serviced pulse
    input wire irq_ack_cfa_i, // compare a interrupt serviced pulse
    input wire irq_ack_cfb_i, // compare b interrupt serviced pulse
    output reg [31:0] avs_readdata_o, // read data
    output reg avs_waitrequest_o, // stall until answer ready
    output reg avs_response_ok_o, // high when last access hit a mapped address
    output reg pin_a_o, // compare pin a output value
    output reg pin_a_oe_n_o, // compare pin a enable, low drives
    output reg pin_b_o, // compare pin b output value
    output reg pin_b_oe_n_o, // compare pin b enable, low drives
    output reg overflow_flag_o, // overflow flag
    output reg compare_flag_a_o, // compare flag a
    output reg compare_flag_b_o // compare flag b
);

//------------------------------------------------------------
// state
//------------------------------------------------------------
reg [7:0] counter_value_reg;
reg [7:0] compare_value_a_reg;
reg [7:0] compare_value_b_reg;
reg [2:0] waveform_mode_field_reg;
reg [1:0] output_action_field_a_reg;
reg [1:0] output_action_field_b_reg;
reg compare_pin_direction_a_reg;
reg compare_pin_direction_b_reg;
reg port_latch_a_reg;
reg port_latch_b_reg;
reg compare_output_state_a_reg;
reg compare_output_state_b_reg;
reg block_pend_reg;
reg block_now_reg;
reg match_a_reg;
reg match_b_reg;
reg done_reg;

//------------------------------------------------------------
// register map, one byte per word in the low lane
//------------------------------------------------------------
// word 0 control: mode in bits 2..0, action a in 5..4, action b in 7..6
// word 0 bits 8 and 9 are force strobes for a and b, they read as zero
// word 1 counter value, word 2 compare a, word 3 compare b
// word 4 flags: overflow, compare a, compare b; writing one clears
// word 5 pins: direction a/b, latch a/b, then compare states read-only
// words 6 and above read zero, ignore writes and report not ok
// the upper three lanes are ignored except for the strobe lane
//
// timing overview
// a bus write lands at the edge that takes it, the same edge that brings the
// answer, so a read right after a write already sees the new value
// the counter moves only on tick_i; between ticks it stands still
// a match found at one tick raises its flag at the following tick,
// which leaves one tick of delay between equality and the flag
// pin outputs follow state and settings one clock later because they
// are registered; software polling the pins must allow for that
// a counter write arms a block that lasts up to and including the
// next tick, so a counter stopped for a long time keeps the block

//------------------------------------------------------------
// helpers
//------------------------------------------------------------
// non-pwm action at a match or force; zero holds the state
function next_state;
    input [1:0] act;
    input cur;
    begin
        case (act)
            `TMC_COM_TOGGLE: next_state = ~cur;
            `TMC_COM_CLEAR: next_state = 1'b0;
            `TMC_COM_SET: next_state = 1'b1;
            default: next_state = cur;
        endcase
    end
endfunction

// byte-lane merge so partial writes keep untouched bits
function [7:0] lane;
    input [7:0] old;
    input [7:0] nw;
    input en;
    begin
        lane = en ? nw : old;
    end
endfunction

//------------------------------------------------------------
// bus decode
//------------------------------------------------------------
wire req = (avs_read_i | avs_write_i) & ~done_reg;
wire wr = avs_write_i & ~done_reg;
wire wr_ctrl = wr & (avs_address_i == `TMC_ADDR_CTRL);
wire wr_count = wr & (avs_address_i == `TMC_ADDR_COUNT) & avs_byteenable_i[0];
wire wr_cmpa = wr & (avs_address_i == `TMC_ADDR_CMPA) & avs_byteenable_i[0];
wire wr_cmpb = wr & (avs_address_i == `TMC_ADDR_CMPB) & avs_byteenable_i[0];
wire wr_flags = wr & (avs_address_i == `TMC_ADDR_FLAGS) & avs_byteenable_i[0];
wire wr_pins = wr & (avs_address_i == `TMC_ADDR_PINS) & avs_byteenable_i[0];
wire mapped = (avs_address_i <= `TMC_ADDR_PINS);
// only lane zero carries the byte registers; lane one carries the
// force strobes of the control word
wire force_a = wr_ctrl & avs_byteenable_i[1] & avs_writedata_i[`TMC_CTRL_FOCA];
wire force_b = wr_ctrl & avs_byteenable_i[1] & avs_writedata_i[`TMC_CTRL_FOCB];
wire non_pwm = (waveform_mode_field_reg == `TMC_WGM_NORMAL) | (waveform_mode_field_reg == `TMC_WGM_CTC);
wire is_ctc = (waveform_mode_field_reg == `TMC_WGM_CTC);

//------------------------------------------------------------
// force actions
//------------------------------------------------------------
// a control write that carries both a new action field and a force
// strobe applies the new action; otherwise software would need two
// writes to establish a known state before enabling the pin
wire ctrl_low_wr = wr_ctrl & avs_byteenable_i[0];
wire [1:0] force_act_a = ctrl_low_wr ?
    avs_writedata_i[`TMC_CTRL_COMA_HI:`TMC_CTRL_COMA_LO] : output_action_field_a_reg;
wire [1:0] force_act_b = ctrl_low_wr ?
    avs_writedata_i[`TMC_CTRL_COMB_HI:`TMC_CTRL_COMB_LO] : output_action_field_b_reg;
// matches in the same cycle still use the stored field

//------------------------------------------------------------
// compare and count
//------------------------------------------------------------
// the pending match is dropped while the block window is open
wire eq_a = (counter_value_reg == compare_value_a_reg) & ~block_now_reg;
wire eq_b = (counter_value_reg == compare_value_b_reg) & ~block_now_reg;
wire top_ctc = is_ctc & eq_a;
wire [7:0] cnt_inc = counter_value_reg + `TMC_CNT_ONE;
wire [7:0] cnt_step = top_ctc ? `TMC_CNT_ZERO : cnt_inc;
// overflow is the ff to 00 step; in clear-on-match mode a top equal to
// ff clears to zero through the match, which is not counted as a wrap
wire wrap = (counter_value_reg == `TMC_CNT_MAX) & ~top_ctc;

// the done register keeps a held request from being taken twice; the
// cycle after an answer is the release cycle for the master
// readdata holds until the next request so late sampling still works
// bus handshake: one wait cycle, then answer with waitrequest low
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        avs_waitrequest_o <= 1'b1;
        avs_readdata_o <= `TMC_WORD_ZERO;
        avs_response_ok_o <= 1'b0;
        done_reg <= 1'b0;
    end else if (ce_i) begin
        if (req) begin
            avs_waitrequest_o <= 1'b0;
            done_reg <= 1'b1;
            avs_response_ok_o <= mapped;
            avs_readdata_o <= `TMC_WORD_ZERO;
            case (avs_address_i)
                `TMC_ADDR_CTRL: avs_readdata_o <= {24'h000000, output_action_field_b_reg,
                    output_action_field_a_reg, 1'b0, waveform_mode_field_reg};
                `TMC_ADDR_COUNT: avs_readdata_o <= {24'h000000, counter_value_reg};
                `TMC_ADDR_CMPA: avs_readdata_o <= {24'h000000, compare_value_a_reg};
                `TMC_ADDR_CMPB: avs_readdata_o <= {24'h000000, compare_value_b_reg};
                `TMC_ADDR_FLAGS: avs_readdata_o <= {29'h00000000, compare_flag_b_o,
                    compare_flag_a_o, overflow_flag_o};
                `TMC_ADDR_PINS: avs_readdata_o <= {26'h0000000, compare_output_state_b_reg,
                    compare_output_state_a_reg, port_latch_b_reg, port_latch_a_reg,
                    compare_pin_direction_b_reg, compare_pin_direction_a_reg};
                default: avs_readdata_o <= `TMC_WORD_ZERO;
            endcase
        end else begin
            avs_waitrequest_o <= 1'b1;
            done_reg <= 1'b0;
        end
    end
end

// compare values and action fields are unbuffered in the non-pwm modes:
// a new value is compared from the very next clock, and a value below
// the current count is missed until the counter wraps through ff
// partial writes keep the old byte when lane zero is not enabled
// configuration registers, written directly with no shadow copies
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        waveform_mode_field_reg <= `TMC_WGM_NORMAL;
        output_action_field_a_reg <= `TMC_COM_NONE;
        output_action_field_b_reg <= `TMC_COM_NONE;
        compare_value_a_reg <= `TMC_CNT_ZERO;
        compare_value_b_reg <= `TMC_CNT_ZERO;
        compare_pin_direction_a_reg <= 1'b0;
        compare_pin_direction_b_reg <= 1'b0;
        port_latch_a_reg <= 1'b0;
        port_latch_b_reg <= 1'b0;
    end else if (ce_i) begin
        if (wr_ctrl & avs_byteenable_i[0]) begin
            waveform_mode_field_reg <= avs_writedata_i[`TMC_CTRL_WGM_HI:`TMC_CTRL_WGM_LO];
            output_action_field_a_reg <= avs_writedata_i[`TMC_CTRL_COMA_HI:`TMC_CTRL_COMA_LO];
            output_action_field_b_reg <= avs_writedata_i[`TMC_CTRL_COMB_HI:`TMC_CTRL_COMB_LO];
        end
        // unbuffered compare values: a value below the count forces a wrap
        compare_value_a_reg <= lane(compare_value_a_reg, avs_writedata_i[7:0], wr_cmpa);
        compare_value_b_reg <= lane(compare_value_b_reg, avs_writedata_i[7:0], wr_cmpb);
        if (wr_pins) begin
            compare_pin_direction_a_reg <= avs_writedata_i[`TMC_PIN_DIRA];
            compare_pin_direction_b_reg <= avs_writedata_i[`TMC_PIN_DIRB];
            port_latch_a_reg <= avs_writedata_i[`TMC_PIN_LATA];
            port_latch_b_reg <= avs_writedata_i[`TMC_PIN_LATB];
        end
    end
end

// the write path sits ahead of the tick path so a counter write in a
// tick cycle wins and that tick is lost; the block window opens at the
// write and closes at the following tick, matching only at ticks
// counter and match blocking; a write arms a block for the next tick
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        counter_value_reg <= `TMC_CNT_ZERO;
        block_pend_reg <= 1'b0;
        block_now_reg <= 1'b0;
    end else if (ce_i) begin
        if (wr_count) begin
            counter_value_reg <= avs_writedata_i[7:0];
            block_pend_reg <= 1'b1;
            block_now_reg <= 1'b1;
        end else if (tick_i) begin
            counter_value_reg <= cnt_step;
            block_pend_reg <= 1'b0;
            block_now_reg <= 1'b0;
        end else begin
            // block stays open until the next tick consumes it, even when stopped
            block_now_reg <= block_pend_reg;
        end
    end
end

// trade-off: the flag sets and clears share one process so that a set
// and a clear in the same cycle resolve in favour of the set; losing
// an event is worse than servicing one twice
// interrupt acknowledge pulses are honoured in any cycle, not only on
// ticks, since service happens at bus speed
// flags: set wins over clear; matches set their flag one tick later
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        overflow_flag_o <= 1'b0;
        compare_flag_a_o <= 1'b0;
        compare_flag_b_o <= 1'b0;
        match_a_reg <= 1'b0;
        match_b_reg <= 1'b0;
    end else if (ce_i) begin
        if (tick_i & ~wr_count) begin
            match_a_reg <= eq_a;
            match_b_reg <= eq_b;
        end else if (tick_i) begin
            match_a_reg <= 1'b0;
            match_b_reg <= 1'b0;
        end
        // force strobes never reach these flags
        if (tick_i & ~wr_count & wrap & non_pwm)
            overflow_flag_o <= 1'b1;
        else if (irq_ack_ovf_i | (wr_flags & avs_writedata_i[`TMC_FLAG_TOV]))
            overflow_flag_o <= 1'b0;
        if (tick_i & match_a_reg)
            compare_flag_a_o <= 1'b1;
        else if (irq_ack_cfa_i | (wr_flags & avs_writedata_i[`TMC_FLAG_CFA]))
            compare_flag_a_o <= 1'b0;
        if (tick_i & match_b_reg)
            compare_flag_b_o <= 1'b1;
        else if (irq_ack_cfb_i | (wr_flags & avs_writedata_i[`TMC_FLAG_CFB]))
            compare_flag_b_o <= 1'b0;
    end
end

// forces and matches share one update so the two cannot both apply in
// one cycle; the force wins because software asked for it explicitly
// the mode field is never read here except to gate pwm modes out, so
// switching modes keeps whatever state was last produced
// compare output states; mode changes never touch them
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        compare_output_state_a_reg <= 1'b0;
        compare_output_state_b_reg <= 1'b0;
    end else if (ce_i) begin
        if (force_a & non_pwm)
            compare_output_state_a_reg <= next_state(force_act_a,
                compare_output_state_a_reg);
        else if (tick_i & ~wr_count & eq_a & non_pwm)
            compare_output_state_a_reg <= next_state(output_action_field_a_reg,
                compare_output_state_a_reg);
        if (force_b & non_pwm)
            compare_output_state_b_reg <= next_state(force_act_b,
                compare_output_state_b_reg);
        else if (tick_i & ~wr_count & eq_b & non_pwm)
            compare_output_state_b_reg <= next_state(output_action_field_b_reg,
                compare_output_state_b_reg);
    end
end

// limitation: the pin load outside is not modelled here; a released
// pin floats unless the board pulls it, so raise the direction only
// after the compare state is known
// the override follows the action field even in modes that never
// change the state, so a nonzero field with a pwm mode shows a frozen
// state on the pin
// pin mux: override chosen by action field only, direction by the dir bit
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        pin_a_o <= 1'b0;
        pin_b_o <= 1'b0;
        pin_a_oe_n_o <= 1'b1;
        pin_b_oe_n_o <= 1'b1;
    end else if (ce_i) begin
        pin_a_o <= (|output_action_field_a_reg) ? compare_output_state_a_reg : port_latch_a_reg;
        pin_b_o <= (|output_action_field_b_reg) ? compare_output_state_b_reg : port_latch_b_reg;
        pin_a_oe_n_o <= ~compare_pin_direction_a_reg;
        pin_b_oe_n_o <= ~compare_pin_direction_b_reg;
    end
end

endmodule // tmc_timer8
`default_nettype wire

// [verif/tmc_pin_load.sv]
`timescale 1ns/1ns
`default_nettype none
// pin load: shows the driven value, or the inverse of the last driven value once released
module tmc_pin_load (
    input wire logic clk_i, // clock
    input wire logic value_i, // pin value
    input wire logic oe_n_i, // low drives
    output logic level_o // wire level
);
    logic last_reg = 1'b0;
    // no pull on this net, so a released pin must not keep the old value
    always @(posedge clk_i) begin
        if (!oe_n_i) begin
            last_reg <= value_i;
        end
    end
    assign level_o = oe_n_i ? ~last_reg : value_i;
endmodule // tmc_pin_load
`default_nettype wire

// [verif/tmc_timer8_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module tmc_timer8_chk (
    input wire logic ref_clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic ce_i, // enable
    input wire logic tick_i, // timer tick
    input wire logic [3:0] avs_address_i, // address
    input wire logic avs_read_i, // read
    input wire logic avs_write_i, // write
    input wire logic [31:0] avs_writedata_i, // data
    input wire logic irq_ack_ovf_i, // ack
    input wire logic avs_waitrequest_o, // stall
    input wire logic pin_a_o, // pin a
    input wire logic pin_a_oe_n_o, // pin a enable
    input wire logic overflow_flag_o, // overflow
    input wire logic compare_flag_a_o // flag a
);
    logic dir_reg, lat_reg;
    logic [1:0] act_reg;
    wire take = avs_write_i && avs_waitrequest_o && ce_i;
    // shadow pin a controls, updated at the same edge as the design
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            {dir_reg, lat_reg, act_reg} <= 4'h0;
        end else if (take && avs_address_i == 4'h5) begin
            {lat_reg, dir_reg} <= {avs_writedata_i[2], avs_writedata_i[0]};
        end else if (take && avs_address_i == 4'h0) begin
            act_reg <= avs_writedata_i[5:4];
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    answer_next_a: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("late answer");
    reset_clear_a: assert property (disable iff (1'b0)
        rst_i |=> pin_a_oe_n_o && !pin_a_o && !overflow_flag_o && !compare_flag_a_o) else $error("bad reset");
    flag_on_tick_a: assert property (
        $rose(overflow_flag_o) || $rose(compare_flag_a_o) |-> $past(tick_i)) else $error("flag off tick");
    ack_clear_a: assert property (
        irq_ack_ovf_i && !tick_i |=> !overflow_flag_o) else $error("ack kept flag");
    write_one_a: assert property (
        take && avs_address_i == 4'h4 && avs_writedata_i[1] && !tick_i |=> !compare_flag_a_o) else $error("w1c failed");
    force_flag_a: assert property (
        take && avs_address_i == 4'h0 && avs_writedata_i[8] && !tick_i
        |=> $stable(compare_flag_a_o) && $stable(overflow_flag_o)) else $error("force set flag");
    dir_oe_a: assert property (
        pin_a_oe_n_o == !$past(dir_reg)) else $error("enable off direction");
    latch_path_a: assert property (
        $past(act_reg) == 2'h0 && !pin_a_oe_n_o |-> pin_a_o == $past(lat_reg)) else $error("latch not on pin");
    cover property (take && avs_address_i == 4'h0 && avs_writedata_i[8]);
    cover property ($rose(overflow_flag_o));
    cover property ($rose(compare_flag_a_o));
endmodule // tmc_timer8_chk
bind tmc_timer8 tmc_timer8_chk chk_i (.ref_clk_i, .rst_i, .ce_i, .tick_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .irq_ack_ovf_i, .avs_waitrequest_o, .pin_a_o, .pin_a_oe_n_o,
    .overflow_flag_o, .compare_flag_a_o);
`default_nettype wire

// [verif/tb_timer8_compare_output_normal_ctc.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_timer8_compare_output_normal_ctc;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, tick_i = 1'b0, ack = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, q[$];
    logic [7:0] r;
    logic [1:0] act_t [0:3] = '{2'h3, 2'h2, 2'h1, 2'h0};
    logic st_t [0:3] = '{1'b1, 1'b0, 1'b1, 1'b1};
    wire [31:0] rdata;
    wire wreq, rok, pa, pa_n, pb, pb_n, ovf, cfa, cfb, pad_a, pad_b;
    integer error_cnt = 0, compares = 0, seed = 32'h01072214;
    always #5 ref_clk_i = ~ref_clk_i;
    tmc_timer8 tmc_timer8_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1), .tick_i(tick_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(4'h3), .irq_ack_ovf_i(ack), .irq_ack_cfa_i(ack), .irq_ack_cfb_i(ack),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .avs_response_ok_o(rok), .pin_a_o(pa),
        .pin_a_oe_n_o(pa_n), .pin_b_o(pb), .pin_b_oe_n_o(pb_n), .overflow_flag_o(ovf),
        .compare_flag_a_o(cfa), .compare_flag_b_o(cfb));
    tmc_pin_load pad_a_i (.clk_i(ref_clk_i), .value_i(pa), .oe_n_i(pa_n), .level_o(pad_a));
    tmc_pin_load pad_b_i (.clk_i(ref_clk_i), .value_i(pb), .oe_n_i(pb_n), .level_o(pad_b));
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task stop_test;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // one access: held until waitrequest is seen low; reads note their expectation
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic t);
        integer n;
        n = 0;
        wr <= w;
        rd <= !w;
        adr <= a;
        wdat <= d;
        tick_i <= t;
        if (!w) q.push_back(d);
        @(posedge ref_clk_i);
        tick_i <= 1'b0;
        while (wreq && n < 50) begin
            @(posedge ref_clk_i);
            n++;
        end
        if (n == 50) error_cnt++;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task w(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 1'b0);
    endtask
    task rr(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, e, 1'b0);
    endtask
    task tk(input int n);
        repeat (n) begin
            tick_i <= 1'b1;
            @(posedge ref_clk_i);
            tick_i <= 1'b0;
            @(posedge ref_clk_i);
        end
    endtask
    // read results are matched against the oldest note in the order issued
    always @(posedge ref_clk_i) if (rd && !wreq) chk($sformatf("reg%0h", adr), q.pop_front(), rdata);
    // hang guard, far beyond the 156 cycles of the run
    initial begin
        #200000;
        error_cnt++;
        stop_test;
    end
    initial begin
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rr(4'h0, 32'h0);
        rr(4'h5, 32'h0);
        rr(4'h6, 32'h0);
        chk("response_ok", 32'h0, rok);
        bus(1'b1, 4'h1, 32'hfe, 1'b1);
        rr(4'h1, 32'hfe);
        tk(1);
        rr(4'h1, 32'hff);
        tk(1);
        rr(4'h1, 32'h0);
        chk("overflow", 32'h1, ovf);
        ack <= 1'b1;
        @(posedge ref_clk_i);
        ack <= 1'b0;
        @(posedge ref_clk_i);
        chk("overflow", 32'h0, ovf);
        r = 8'h10 + 8'($random(seed) & 32'h3f);
        w(4'h2, r);
        w(4'h1, r);
        tk(2);
        chk("cmp_a", 32'h0, cfa);
        w(4'h1, r - 2);
        tk(2);
        rr(4'h1, r);
        chk("cmp_a", 32'h0, cfa);
        tk(2);
        chk("cmp_a", 32'h1, cfa);
        w(4'h4, 32'h2);
        chk("cmp_a", 32'h0, cfa);
        // every action code forced in normal mode, pin still an input
        for (int i = 0; i < 4; i++) begin
            w(4'h0, 32'h100 | {act_t[i], 4'h0});
            rr(4'h5, {st_t[i], 4'h0});
        end
        rr(4'h1, r + 2);
        chk("cmp_a", 32'h0, cfa);
        w(4'h5, 32'h1);
        chk("pad_a", 32'h0, pad_a);
        w(4'h0, 32'h30);
        chk("pad_a", 32'h1, pad_a);
        chk("oe_n_a", 32'h0, pa_n);
        w(4'h5, 32'h4);
        chk("oe_n_a", 32'h1, pa_n);
        w(4'h5, 32'h1);
        w(4'h0, 32'h12);
        rr(4'h5, 32'h11);
        chk("pad_a", 32'h1, pad_a);
        w(4'h2, 32'h3);
        w(4'h1, 32'h0);
        tk(4);
        rr(4'h1, 32'h0);
        rr(4'h5, 32'h1);
        tk(1);
        chk("cmp_a", 32'h1, cfa);
        chk("overflow", 32'h0, ovf);
        w(4'h2, 32'h2);
        w(4'h1, 32'hfe);
        tk(2);
        rr(4'h1, 32'h0);
        chk("overflow", 32'h1, ovf);
        w(4'h0, 32'h2);
        tk(3);
        rr(4'h5, 32'h1);
        stop_test;
    end
endmodule // tb_timer8_compare_output_normal_ctc
`default_nettype wire
